// >>> rtl/gpio_port.sv
// General-purpose I/O port with alternative functions and startup straps
//
// How it works
// - Eighteen lines, each input or output
// - Open driver first; close line before reconfiguring
// - Unconfigured or closed lines: high-Z, pull-down
// - Input lines: high-Z, no pull resistor
// - Input-line change on wake lines wakes sleep
// - Line 1 may output one-pulse-per-second
// - Line 2 high at startup swaps firmware
// - Line 20 low at startup: download mode
// - Lines 12-14 fixed antenna switch outputs
// - Lines 9, 10 may carry debug serial
// - Lines 15, 17 may enable radio chips
// - Lines 18-21 offer no alternative function
// - Line 11 may reset audio codec
`timescale 1ns/1ps
module gpio_port
  import gpio_pkg::*;
(
  input  wire logic                mclk_in,                     // System clock
  input  wire logic                nrst_in,                     // Async reset, active low
  input  wire logic                driver_open_in,              // Port driver opened
  input  wire logic                cmd_valid_in,                // Config command strobe
  input  wire logic [1:0]          cmd_in,                      // Config command code
  input  wire logic [4:0]          line_sel_in,                 // Target line number
  input  wire logic [LINE_W-1:0]   out_level_in,                // Levels for output lines
  input  wire logic [LINE_W-1:0]   pad_in,                      // Pad input levels
  input  wire logic                sleep_in,                    // Power-save sleep active
  input  wire logic                startup_in,                  // Startup phase active
  input  wire logic                dead_reckoning_pulse_in,     // 1PPS source
  input  wire logic                debug_serial_out_in,         // Debug serial transmit data
  input  wire logic                codec_reset_in,              // Codec reset request
  input  wire logic                wireless_lan_enable_in,      // WLAN chip enable
  input  wire logic                short_range_radio_enable_in, // Radio chip enable
  input  wire logic                antenna_select_a_in,         // Antenna switch bit a
  input  wire logic                antenna_select_b_in,         // Antenna switch bit b
  input  wire logic                antenna_select_c_in,         // Antenna switch bit c
  output logic [LINE_W-1:0]        pad_out,                     // Pad output levels
  output logic [LINE_W-1:0]        pad_oe_out,                  // Pad drive enables
  output logic [LINE_W-1:0]        pad_pd_out,                  // Pull-down enables
  output logic [LINE_W-1:0]        in_level_out,                // Levels of input lines
  output logic                     debug_serial_in_out,         // Debug serial receive data
  output logic                     cmd_done_out,                // Command accepted pulse
  output logic                     cmd_error_out,               // Command refused pulse
  output logic                     wake_out,                    // Wake request pulse
  output logic                     straps_valid_out,            // Straps captured
  output logic                     firmware_variant_select_out, // Swap firmware variant
  output logic                     download_mode_out            // Enter download mode
);
  import gpio_pkg::*;

  typedef struct packed {
    line_state_t [LINE_W-1:0] ls;
    logic [LINE_W-1:0]        pad_o;
    logic [LINE_W-1:0]        pad_oe;
    logic [LINE_W-1:0]        pad_pd;
    logic [LINE_W-1:0]        in_lvl;
    logic                     dbg_rx;
    logic                     done;
    logic                     err;
    logic                     wake;
    logic                     straps_done;
    logic                     fw_swap;
    logic                     download;
  } port_state_t;

  port_state_t       st;
  port_state_t       next_st;
  logic [LINE_W-1:0] alt_src;
  logic [LINE_W-1:0] in_vec;
  logic [LINE_W-1:0] wake_en;
  logic              change;
  logic              accept;

  function automatic logic [LINE_W-1:0] state_vec(input port_state_t s,
                                                   input line_state_t want);
    logic [LINE_W-1:0] v;
    v = '0;
    for (int i = 0; i < LINE_W; i++) begin
      v[i] = (s.ls[i] == want);
    end
    return v;
  endfunction : state_vec

  // ----------------------------------------------------------------------
  // Wake detection
  // ----------------------------------------------------------------------
  assign in_vec  = state_vec(st, LS_INPUT);
  assign wake_en = in_vec & WAKE_MASK;

  wake_detect u_wake (
    .mclk_in    (mclk_in),
    .nrst_in    (nrst_in),
    .pad_in     (pad_in),
    .enable_in  (wake_en),
    .change_out (change)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    alt_src                 = '0;
    alt_src[LINE_PPS]       = dead_reckoning_pulse_in;
    alt_src[LINE_DBG_TX]    = debug_serial_out_in;
    alt_src[LINE_CODEC_RST] = codec_reset_in;
    alt_src[LINE_WLAN]      = wireless_lan_enable_in;
    alt_src[LINE_RADIO]     = short_range_radio_enable_in;
    alt_src[LINE_ANT_A]     = antenna_select_a_in;
    alt_src[LINE_ANT_B]     = antenna_select_b_in;
    alt_src[LINE_ANT_C]     = antenna_select_c_in;
  end

  // Only closed lines take a new setting; close is allowed in any line state
  // Range test first: a line number past the map would read unknown
  assign accept = driver_open_in && (int'(line_sel_in) < LINE_W)
               && GPIO_MASK[line_sel_in]
               && (cmd_in == CMD_CLOSE || st.ls[line_sel_in] == LS_CLOSED)
               && (cmd_in != CMD_ALT || ALT_MASK[line_sel_in]);

  always_comb begin
    next_st      = st;
    next_st.done = cmd_valid_in && accept;
    next_st.err  = cmd_valid_in && !accept;
    if (cmd_valid_in && accept) begin
      unique case (cmd_in)
        CMD_INPUT:  next_st.ls[line_sel_in] = LS_INPUT;
        CMD_OUTPUT: next_st.ls[line_sel_in] = LS_OUTPUT;
        CMD_ALT:    next_st.ls[line_sel_in] = LS_ALT;
        default:    next_st.ls[line_sel_in] = LS_CLOSED;
      endcase
    end
    // Closing the driver closes every line
    if (!driver_open_in) begin
      for (int i = 0; i < LINE_W; i++) begin
        next_st.ls[i] = LS_CLOSED;
      end
    end
    for (int i = 0; i < LINE_W; i++) begin
      next_st.pad_o[i]  = 1'b0;
      next_st.pad_oe[i] = 1'b0;
      next_st.pad_pd[i] = 1'b0;
      unique case (st.ls[i])
        LS_CLOSED: next_st.pad_pd[i] = 1'b1;
        LS_INPUT:  next_st.pad_pd[i] = 1'b0;
        LS_OUTPUT: begin
          next_st.pad_oe[i] = 1'b1;
          next_st.pad_o[i]  = out_level_in[i];
        end
        LS_ALT: begin
          next_st.pad_oe[i] = (i != int'(LINE_DBG_RX));
          next_st.pad_o[i]  = alt_src[i];
        end
      endcase
    end
    next_st.pad_o  = (next_st.pad_o & GPIO_MASK) | (alt_src & ANT_MASK);
    next_st.pad_oe = (next_st.pad_oe & GPIO_MASK) | ANT_MASK;
    next_st.pad_pd = next_st.pad_pd & GPIO_MASK;
    next_st.in_lvl = pad_in & in_vec;
    next_st.dbg_rx = (st.ls[LINE_DBG_RX] == LS_ALT) && pad_in[LINE_DBG_RX];
    next_st.wake   = sleep_in && change;
    // Straps are taken on the first startup cycle after reset and never again until the next reset
    if (startup_in && !st.straps_done) begin
      next_st.straps_done = 1'b1;
      next_st.fw_swap     = pad_in[LINE_FW_SWAP];
      next_st.download    = !pad_in[LINE_DOWNLOAD];
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < LINE_W; i++) begin
        st.ls[i] <= LS_CLOSED;
      end
      st.pad_o       <= '0;
      st.pad_oe      <= '0;
      st.pad_pd      <= GPIO_MASK;
      st.in_lvl      <= '0;
      st.dbg_rx      <= 1'b0;
      st.done        <= 1'b0;
      st.err         <= 1'b0;
      st.wake        <= 1'b0;
      st.straps_done <= 1'b0;
      st.fw_swap     <= 1'b0;
      st.download    <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign pad_out                     = st.pad_o;
  assign pad_oe_out                  = st.pad_oe;
  assign pad_pd_out                  = st.pad_pd;
  assign in_level_out                = st.in_lvl;
  assign debug_serial_in_out         = st.dbg_rx;
  assign cmd_done_out                = st.done;
  assign cmd_error_out               = st.err;
  assign wake_out                    = st.wake;
  assign straps_valid_out            = st.straps_done;
  assign firmware_variant_select_out = st.fw_swap;
  assign download_mode_out           = st.download;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  a_line_count: assert property (
    $countones(GPIO_MASK) == LINE_COUNT && ((pad_oe_out | pad_out) & ~PIN_MASK) == '0
    && (pad_pd_out & ~GPIO_MASK) == '0)
    else $error("Line without a pad is driven or pulled");
  a_refuse_busy: assert property (
    cmd_valid_in && cmd_in != CMD_CLOSE && st.ls[line_sel_in] != LS_CLOSED
    |=> cmd_error_out && !cmd_done_out)
    else $error("Reconfiguring an open line was not refused");
  a_closed_pull: assert property (
    !driver_open_in |=> ##1 (pad_pd_out & GPIO_MASK) == GPIO_MASK
    && (pad_oe_out & GPIO_MASK) == '0)
    else $error("Closed driver does not leave lines pulled down");
  a_input_nopull: assert property (
    1'b1 |=> (pad_pd_out & $past(in_vec)) == '0 && (pad_oe_out & $past(in_vec)) == '0)
    else $error("Input line is pulled or driven");
  a_wake_pulse: assert property (
    $past(nrst_in, 2) && sleep_in && |((pad_in ^ $past(pad_in)) & wake_en) |=> wake_out)
    else $error("Wake line change did not wake");
  a_pps_follow: assert property (
    st.ls[LINE_PPS] == LS_ALT |=> pad_oe_out[LINE_PPS]
    && pad_out[LINE_PPS] == $past(dead_reckoning_pulse_in))
    else $error("Pulse line does not follow the pulse source");
  a_strap_take: assert property (
    startup_in && !straps_valid_out |=> straps_valid_out
    && firmware_variant_select_out == $past(pad_in[LINE_FW_SWAP])
    && download_mode_out == !$past(pad_in[LINE_DOWNLOAD]))
    else $error("Startup straps were not captured");
  a_antenna_fixed: assert property (
    1'b1 |=> pad_oe_out[LINE_ANT_C:LINE_ANT_A] == 3'h7
    && pad_out[LINE_ANT_C:LINE_ANT_A]
       == $past({antenna_select_c_in, antenna_select_b_in, antenna_select_a_in}))
    else $error("Antenna switch lines not driven");
  a_debug_rx: assert property (
    st.ls[LINE_DBG_RX] == LS_ALT |=> debug_serial_in_out == $past(pad_in[LINE_DBG_RX])
    && !pad_oe_out[LINE_DBG_RX])
    else $error("Debug receive line wrong");
  a_radio_enable: assert property (
    st.ls[LINE_WLAN] == LS_ALT |=> pad_out[LINE_WLAN] == $past(wireless_lan_enable_in))
    else $error("Wireless enable line wrong");
  a_modem_refuse: assert property (
    cmd_valid_in && cmd_in == CMD_ALT && MODEM_MASK[line_sel_in] |=> cmd_error_out)
    else $error("Modem line accepted an alternative function");
  a_codec_reset: assert property (
    st.ls[LINE_CODEC_RST] == LS_ALT |=> pad_out[LINE_CODEC_RST] == $past(codec_reset_in))
    else $error("Codec reset line wrong");
  a_strap_hold: assert property (
    straps_valid_out |=> $stable(firmware_variant_select_out) && $stable(download_mode_out))
    else $error("Strap value changed after capture");

  c_wake:     cover property (sleep_in ##1 wake_out);
  c_swap:     cover property (straps_valid_out && firmware_variant_select_out);
  c_refused:  cover property (cmd_valid_in ##1 cmd_error_out);
  c_download: cover property (straps_valid_out && download_mode_out);

endmodule : gpio_port

// >>> shared/gpio_pkg.sv
// Constants, line map and state encodings for the general-purpose I/O port
package gpio_pkg;

  // ----------------------------------------------------------------------
  // Line map (bit index equals line number; bits 0 and 3 have no pad)
  // ----------------------------------------------------------------------
  localparam int          LINE_W         = 23;
  localparam int          LINE_COUNT     = 18;
  localparam logic [4:0]  LINE_PPS       = 5'h01;
  localparam logic [4:0]  LINE_FW_SWAP   = 5'h02;
  localparam logic [4:0]  LINE_DBG_RX    = 5'h09;
  localparam logic [4:0]  LINE_DBG_TX    = 5'h0a;
  localparam logic [4:0]  LINE_CODEC_RST = 5'h0b;
  localparam logic [4:0]  LINE_ANT_A     = 5'h0c;
  localparam logic [4:0]  LINE_ANT_B     = 5'h0d;
  localparam logic [4:0]  LINE_ANT_C     = 5'h0e;
  localparam logic [4:0]  LINE_WLAN      = 5'h0f;
  localparam logic [4:0]  LINE_RADIO     = 5'h11;
  localparam logic [4:0]  LINE_DOWNLOAD  = 5'h14;

  // ----------------------------------------------------------------------
  // Line groups
  // ----------------------------------------------------------------------
  localparam logic [22:0] GPIO_MASK  = 23'h7f8ff6;
  localparam logic [22:0] PIN_MASK   = 23'h7ffff6;
  localparam logic [22:0] ANT_MASK   = 23'h007000;
  localparam logic [22:0] ALT_MASK   = 23'h028e02;
  localparam logic [22:0] WAKE_MASK  = 23'h7101b4;
  localparam logic [22:0] MODEM_MASK = 23'h3c0000;

  // ----------------------------------------------------------------------
  // Configuration commands and per-line states
  // ----------------------------------------------------------------------
  localparam logic [1:0] CMD_CLOSE  = 2'h0;
  localparam logic [1:0] CMD_INPUT  = 2'h1;
  localparam logic [1:0] CMD_OUTPUT = 2'h2;
  localparam logic [1:0] CMD_ALT    = 2'h3;

  typedef enum logic [3:0] {
    LS_CLOSED = 4'h1,
    LS_INPUT  = 4'h2,
    LS_OUTPUT = 4'h4,
    LS_ALT    = 4'h8
  } line_state_t;

endpackage : gpio_pkg

// >>> rtl/wake_detect.sv
// Level-change detector over the wake-capable input lines
`timescale 1ns/1ps
module wake_detect
  import gpio_pkg::*;
(
  input  wire logic              mclk_in,    // System clock
  input  wire logic              nrst_in,    // Async reset, active low
  input  wire logic [LINE_W-1:0] pad_in,     // Pad levels
  input  wire logic [LINE_W-1:0] enable_in,  // Lines allowed to wake
  output logic                   change_out  // Any enabled line changed
);
  import gpio_pkg::*;

  typedef struct packed {
    logic [LINE_W-1:0] prev;
    logic              primed;
  } wake_state_t;

  wake_state_t st;
  wake_state_t next_st;

  always_comb begin
    next_st        = st;
    next_st.prev   = pad_in;
    next_st.primed = 1'b1;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // No history yet on the first cycle, so no false wake after reset
  assign change_out = st.primed && (|((pad_in ^ st.prev) & enable_in));

endmodule : wake_detect

// >>> verif/ext_hw.sv
// Model of the outside hardware attached to the I/O lines
`timescale 1ns/1ps
module ext_hw
  import gpio_pkg::*;
(
  input  wire logic              mclk_in,       // Clock
  input  wire logic              startup_in,    // Startup phase active
  input  wire logic [LINE_W-1:0] drv_en_in,     // Lines driven from outside
  input  wire logic [LINE_W-1:0] drv_level_in,  // Levels driven from outside
  input  wire logic [LINE_W-1:0] dev_out_in,    // Device pad levels
  input  wire logic [LINE_W-1:0] dev_oe_in,     // Device drive enables
  input  wire logic [LINE_W-1:0] dev_pd_in,     // Device pull-downs
  output logic      [LINE_W-1:0] pad_level_out  // Resolved wire levels
);
  logic [LINE_W-1:0] float_pat = 23'h2aaaaa;
  logic [LINE_W-1:0] en;
  logic [LINE_W-1:0] lvl;
  // Undriven lines wander so a stale level never passes for a real one
  always @(posedge mclk_in) float_pat <= ~float_pat;
  always_comb begin
    en  = drv_en_in;
    lvl = drv_level_in;
    if (startup_in) begin
      en  = en | 23'h020080;
      lvl = lvl & ~23'h020080;
    end
    pad_level_out = (dev_oe_in & dev_out_in) | (~dev_oe_in & en & lvl)
                  | (~dev_oe_in & ~en & ~dev_pd_in & float_pat);
  end
endmodule : ext_hw

// >>> verif/gpio_port_test.sv
// Self-checking bench for the general-purpose I/O port
`timescale 1ns/1ps
module gpio_port_test;
  import gpio_pkg::*;
  typedef struct packed {
    logic       open;
    logic [1:0] cmd;
    logic [4:0] line;
    logic       ok;
  } row_t;
  logic              mclk_in = 1'b0;
  logic              nrst_in = 1'b0;
  logic              open = 1'b0;
  logic              valid = 1'b0;
  logic [1:0]        cmd = 2'h0;
  logic [4:0]        line = 5'h00;
  logic              sleep = 1'b0;
  logic              startup = 1'b0;
  logic [4:0]        src = 5'h00;
  logic [2:0]        ant = 3'h0;
  logic [LINE_W-1:0] out_level = 23'h000010;
  logic [LINE_W-1:0] drv_level = 23'h000000;
  logic [LINE_W-1:0] pad, pad_out, pad_oe, pad_pd, in_level;
  logic              dbg_in, done, err, wake, sv, fw, dl;
  int                errors = 0;
  int                n_checks = 0;
  row_t rows [20] = '{
    '{1'b0, CMD_INPUT, 5'h04, 1'b0}, '{1'b1, CMD_INPUT, 5'h04, 1'b1},
    '{1'b1, CMD_OUTPUT, 5'h04, 1'b0}, '{1'b1, CMD_CLOSE, 5'h04, 1'b1},
    '{1'b1, CMD_OUTPUT, 5'h04, 1'b1}, '{1'b1, CMD_INPUT, 5'h0c, 1'b0},
    '{1'b1, CMD_INPUT, 5'h03, 1'b0}, '{1'b1, CMD_ALT, 5'h12, 1'b0},
    '{1'b1, CMD_ALT, 5'h01, 1'b1}, '{1'b1, CMD_ALT, 5'h09, 1'b1},
    '{1'b1, CMD_ALT, 5'h0a, 1'b1}, '{1'b1, CMD_ALT, 5'h0b, 1'b1},
    '{1'b1, CMD_ALT, 5'h0f, 1'b1}, '{1'b1, CMD_ALT, 5'h11, 1'b1},
    '{1'b1, CMD_INPUT, 5'h17, 1'b0}, '{1'b1, CMD_ALT, 5'h05, 1'b0},
    '{1'b1, CMD_INPUT, 5'h05, 1'b1}, '{1'b1, CMD_INPUT, 5'h02, 1'b1},
    '{1'b1, CMD_INPUT, 5'h14, 1'b1}, '{1'b1, CMD_INPUT, 5'h16, 1'b1}};

  always #5 mclk_in = ~mclk_in;

  gpio_port i_gpio_port (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .driver_open_in(open), .cmd_valid_in(valid),
    .cmd_in(cmd), .line_sel_in(line), .out_level_in(out_level), .pad_in(pad),
    .sleep_in(sleep), .startup_in(startup), .dead_reckoning_pulse_in(src[0]),
    .debug_serial_out_in(src[1]), .codec_reset_in(src[2]),
    .wireless_lan_enable_in(src[3]), .short_range_radio_enable_in(src[4]),
    .antenna_select_a_in(ant[0]), .antenna_select_b_in(ant[1]),
    .antenna_select_c_in(ant[2]), .pad_out(pad_out), .pad_oe_out(pad_oe),
    .pad_pd_out(pad_pd), .in_level_out(in_level), .debug_serial_in_out(dbg_in),
    .cmd_done_out(done), .cmd_error_out(err), .wake_out(wake),
    .straps_valid_out(sv), .firmware_variant_select_out(fw), .download_mode_out(dl));

  ext_hw i_ext_hw (
    .mclk_in(mclk_in), .startup_in(startup), .drv_en_in(PIN_MASK),
    .drv_level_in(drv_level), .dev_out_in(pad_out), .dev_oe_in(pad_oe),
    .dev_pd_in(pad_pd), .pad_level_out(pad));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : step

  task automatic check_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_vec(input string what, input logic [22:0] exp,
                           input logic [22:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_vec

  // Answer stands only in the cycle right after the strobe
  task automatic issue(input row_t r);
    open  = r.open;
    cmd   = r.cmd;
    line  = r.line;
    valid = 1'b1;
    step(1);
    valid = 1'b0;
    check_bit("cmd_done", r.ok, done);
    check_bit("cmd_error", !r.ok, err);
    step(1);
    check_bit("answer_drop", 1'b0, done | err);
  endtask : issue

  task automatic watch_wake(input logic exp);
    logic w;
    w = 1'b0;
    repeat (4) begin
      step(1);
      w = w | wake;
    end
    check_bit("wake", exp, w);
  endtask : watch_wake

  // Second strap pass must not move the captured values
  task automatic reset_run(input logic k);
    nrst_in = 1'b0;
    step(8);
    check_vec("pd_in_reset", GPIO_MASK, pad_pd);
    check_vec("oe_in_reset", 23'h000000, pad_oe);
    nrst_in = 1'b1;
    drv_level[2]  = k;
    drv_level[20] = !k;
    step(2);
    startup = 1'b1;
    step(3);
    startup = 1'b0;
    drv_level[2]  = !k;
    drv_level[20] = k;
    step(2);
    startup = 1'b1;
    step(2);
    startup = 1'b0;
    step(1);
    check_bit("straps_valid", 1'b1, sv);
    check_bit("fw_select", k, fw);
    check_bit("download", k, dl);
  endtask : reset_run

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    reset_run(1'b0);
    reset_run(1'b1);
    ant = 3'h5;
    step(2);
    check_vec("ant_level", 23'h005000, pad_out & ANT_MASK);
    check_vec("ant_oe", ANT_MASK, pad_oe & ANT_MASK);
    for (int i = 0; i < 20; i++) begin
      issue(rows[i]);
    end
    src = 5'h1f;
    drv_level = 23'h7fffff;
    step(3);
    check_vec("oe", 23'h02fc12, pad_oe);
    check_vec("out", 23'h02dc12, pad_out);
    check_vec("pd", 23'h2d01c0, pad_pd);
    check_vec("in_level", 23'h500024, in_level);
    check_bit("debug_rx", 1'b1, dbg_in);
    src = 5'h00;
    step(3);
    check_vec("out_idle", 23'h005010, pad_out);
    out_level = 23'h000000;
    ant = 3'h2;
    step(2);
    check_vec("out_low", 23'h002000, pad_out);
    sleep = 1'b1;
    step(2);
    drv_level[5] = 1'b0;
    watch_wake(1'b1);
    drv_level[16] = 1'b0;
    watch_wake(1'b0);
    sleep = 1'b0;
    drv_level[5] = 1'b1;
    watch_wake(1'b0);
    open = 1'b0;
    step(3);
    check_vec("pd_closed", GPIO_MASK, pad_pd);
    check_vec("oe_closed", ANT_MASK, pad_oe);
    issue('{1'b1, CMD_OUTPUT, 5'h05, 1'b1});
    summarize();
  end

  initial begin
    repeat (2000) @(posedge mclk_in);
    errors++;
    summarize();
  end
endmodule : gpio_port_test
